// ### design/svr_regs.sv
// Purpose: source voltage result registers of both channels, byte read port
// Assumes: sequencer inputs and host read strobe are on ref_clk_i
// Notes:   reading a high byte freezes the matching low byte for a coherent pair
//
// How it works
// - ch1 result at 11h high, 12h low
// - ch2 result at 13h high, 14h low
// - low five bits always read zero
// - unsigned code, 19.531 mV per count
// - single-channel part: ch2 reads all zero
// - sample-time select sets reported resolution
`timescale 1ns/1ps
`include "svr_cfg.svh"

module svr_regs
  import svr_pkg::*;
#(
  parameter bit DUAL_CHANNEL = 1'b1,
  parameter int CODE_W       = `SVR_CODE_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [10:0]  ch1_conv_code_i,
  input  wire logic         ch1_conv_done_i,
  input  wire logic [1:0]   ch1_source_sample_time_sel_i,
  input  wire logic [10:0]  ch2_conv_code_i,
  input  wire logic         ch2_conv_done_i,
  input  wire logic [1:0]   ch2_source_sample_time_sel_i,
  input  wire logic         reg_rd_i,
  input  wire logic [7:0]   reg_addr_i,
  output logic      [7:0]   reg_rdata_o,
  output logic              reg_rvalid_o,
  output logic      [15:0]  ch1_source_volt_code_o,
  output logic      [15:0]  ch2_source_volt_code_o
);

  if (CODE_W != `SVR_CODE_W) begin : g_bad_width
    $error("svr_regs: code width must be 11");
  end

  svr_res_if chan_if [`SVR_NUM_CHAN] ();

  svr_code_t    codes [`SVR_NUM_CHAN];
  logic         dones [`SVR_NUM_CHAN];
  svr_res_sel_t sels  [`SVR_NUM_CHAN];
  svr_result_t  res   [`SVR_NUM_CHAN];

  always_comb begin
    codes[0] = ch1_conv_code_i;
    codes[1] = ch2_conv_code_i;
    dones[0] = ch1_conv_done_i;
    dones[1] = ch2_conv_done_i;
    sels[0]  = svr_res_sel_t'(ch1_source_sample_time_sel_i);
    sels[1]  = svr_res_sel_t'(ch2_source_sample_time_sel_i);
  end

  for (genvar c = 0; c < `SVR_NUM_CHAN; c++) begin : g_chan
    assign chan_if[c].code   = codes[c];
    assign chan_if[c].done   = dones[c];
    assign chan_if[c].sel    = sels[c];
    assign chan_if[c].enable = (c == 0) ? 1'b1 : DUAL_CHANNEL;
    assign res[c]            = chan_if[c].result;

    svr_result_reg u_reg (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .res       (chan_if[c])
    );
  end

  assign ch1_source_volt_code_o = res[0];
  assign ch2_source_volt_code_o = res[1];

  // read path with low-byte hold
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic [7:0] lo_hold_r;
  logic [7:0] lo_hold_nxt;
  logic       hold_vld_r;
  logic       hold_vld_nxt;
  logic       hold_ch_r;
  logic       hold_ch_nxt;

  // hold avoids a tear when a conversion lands between the two byte reads
  always_comb begin
    rdata_nxt    = rdata_r;
    rvalid_nxt   = reg_rd_i;
    lo_hold_nxt  = lo_hold_r;
    hold_vld_nxt = hold_vld_r;
    hold_ch_nxt  = hold_ch_r;
    if (reg_rd_i) begin
      hold_vld_nxt = 1'b0;
      case (reg_addr_i)
        `SVR_ADDR_CH1_HI: begin
          rdata_nxt    = res[0][15:8];
          lo_hold_nxt  = res[0][7:0];
          hold_vld_nxt = 1'b1;
          hold_ch_nxt  = 1'b0;
        end
        `SVR_ADDR_CH1_LO: begin
          rdata_nxt = (hold_vld_r && !hold_ch_r) ? lo_hold_r : res[0][7:0];
        end
        `SVR_ADDR_CH2_HI: begin
          rdata_nxt    = res[1][15:8];
          lo_hold_nxt  = res[1][7:0];
          hold_vld_nxt = 1'b1;
          hold_ch_nxt  = 1'b1;
        end
        `SVR_ADDR_CH2_LO: begin
          rdata_nxt = (hold_vld_r && hold_ch_r) ? lo_hold_r : res[1][7:0];
        end
        default: begin
          rdata_nxt = `SVR_UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r    <= 8'h00;
      rvalid_r   <= 1'b0;
      lo_hold_r  <= 8'h00;
      hold_vld_r <= 1'b0;
      hold_ch_r  <= 1'b0;
    end else begin
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
      lo_hold_r  <= lo_hold_nxt;
      hold_vld_r <= hold_vld_nxt;
      hold_ch_r  <= hold_ch_nxt;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

endmodule

// ### design/svr_cfg.svh
// Purpose: addresses, field layout and reset values of the source voltage results
// Assumes: byte-wide register addresses as seen by the management host
// Notes:   definitions only
`ifndef SVR_CFG_SVH
`define SVR_CFG_SVH

`define SVR_ADDR_CH1_HI   8'h11
`define SVR_ADDR_CH1_LO   8'h12
`define SVR_ADDR_CH2_HI   8'h13
`define SVR_ADDR_CH2_LO   8'h14
`define SVR_CODE_W        11
`define SVR_CODE_LSB      5
`define SVR_RESULT_W      16
`define SVR_RESULT_RST    16'h0000
`define SVR_UNMAPPED_DATA 8'h00
`define SVR_NUM_CHAN      2

`endif

// ### design/svr_pkg.sv
// Purpose: shared types of the source voltage result block
// Assumes: constants come from svr_cfg.svh
// Notes:   resolution encoding follows the per-channel sample-time field
`include "svr_cfg.svh"

package svr_pkg;

  typedef logic [`SVR_CODE_W-1:0]   svr_code_t;
  typedef logic [`SVR_RESULT_W-1:0] svr_result_t;

  // sample-time select: longer sample time keeps more significant code bits
  typedef enum logic [1:0] {
    SVR_RES_8B  = 2'b00,
    SVR_RES_9B  = 2'b01,
    SVR_RES_10B = 2'b10,
    SVR_RES_11B = 2'b11
  } svr_res_sel_t;

endpackage

// ### design/svr_res_if.sv
// Purpose: carries one channel's conversion result into its result register
// Assumes: all signals on ref_clk_i
// Notes:   done is a one-cycle pulse from the conversion sequencer
`timescale 1ns/1ps

interface svr_res_if;
  import svr_pkg::*;

  svr_code_t    code;
  logic         done;
  svr_res_sel_t sel;
  logic         enable;
  svr_result_t  result;

  modport reg_side (
    input  code,
    input  done,
    input  sel,
    input  enable,
    output result
  );

  modport top_side (
    output code,
    output done,
    output sel,
    output enable,
    input  result
  );
endinterface

// ### design/svr_result_reg.sv
// Purpose: holds one channel's latest source voltage result, left-justified
// Assumes: code arrives already averaged; done pulses once per conversion
// Notes:   a disabled channel holds zero for good
`timescale 1ns/1ps
`include "svr_cfg.svh"

module svr_result_reg
  import svr_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  svr_res_if.reg_side res
);

  svr_result_t result_r;
  svr_result_t result_nxt;

  // drop code bits below the resolution the sample time supports
  function automatic svr_code_t svr_trim(input svr_code_t code, input svr_res_sel_t sel);
    svr_code_t mask;
    mask = '1;
    case (sel)
      SVR_RES_8B:  mask = 11'h7F8;
      SVR_RES_9B:  mask = 11'h7FC;
      SVR_RES_10B: mask = 11'h7FE;
      SVR_RES_11B: mask = 11'h7FF;
      default:     mask = 11'h7FF;
    endcase
    return code & mask;
  endfunction

  always_comb begin
    result_nxt = result_r;
    if (!res.enable) begin
      result_nxt = `SVR_RESULT_RST;
    end else if (res.done) begin
      // unsigned code, 1 lsb = 19.531 mV, bits 4:0 forced low
      result_nxt = {svr_trim(res.code, res.sel), 5'h00};
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_r <= `SVR_RESULT_RST;
    end else begin
      result_r <= result_nxt;
    end
  end

  assign res.result = result_r;

endmodule

// ### verif/svr_assertions.sv
// Purpose: concurrent checks of the source voltage results
// Assumes: one clock, async active-high reset
// Notes:   bound to every svr_regs instance
`timescale 1ns/1ps
module svr_assertions #(parameter bit DUAL_CHANNEL = 1'b1) (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [10:0] ch1_conv_code_i,
  input wire logic        ch1_conv_done_i,
  input wire logic [1:0]  ch1_source_sample_time_sel_i,
  input wire logic [10:0] ch2_conv_code_i,
  input wire logic        ch2_conv_done_i,
  input wire logic [1:0]  ch2_source_sample_time_sel_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [15:0] ch1_source_volt_code_o,
  input wire logic [15:0] ch2_source_volt_code_o
);
  wire logic [15:0] v1 = ch1_source_volt_code_o;
  wire logic [15:0] v2 = ch2_source_volt_code_o;
  wire logic [10:0] c1 = ch1_conv_code_i;
  wire logic        k1 = ch1_conv_done_i;
  wire logic [7:0]  d  = reg_rdata_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence rq(a); reg_rd_i && reg_addr_i == a; endsequence
  // high byte read, idle cycle, then the matching low byte read
  sequence hi_lo(h, l); rq(h) ##1 !reg_rd_i ##1 rq(l); endsequence
  AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i)) else $error("rv");
  AST_CH1_HI: assert property (rq(8'h11) |=> d == $past(v1[15:8])) else $error("h1");
  AST_CH2_HI: assert property (rq(8'h13) |=> d == $past(v2[15:8])) else $error("h2");
  AST_LOW0: assert property (rq(8'h12) or rq(8'h14) |=> d[4:0] == 5'h00) else $error("lo");
  AST_MSB: assert property (k1 |=> v1[15:8] == $past(c1[10:3])) else $error("msb");
  AST_SINGLE: assert property (DUAL_CHANNEL || v2 == 16'h0000) else $error("ch2");
  AST_FULL: assert property (k1 && ch1_source_sample_time_sel_i == 2'b11 |=>
    v1 == {$past(c1), 5'h00}) else $error("full");
  AST_HOLD: assert property (!k1 |=> $stable(v1)) else $error("hold");
  AST_PAIR1: assert property (hi_lo(8'h11, 8'h12) |=>
    d == $past(v1[7:0], 3)) else $error("p1");
  AST_PAIR2: assert property (hi_lo(8'h13, 8'h14) |=>
    d == $past(v2[7:0], 3)) else $error("p2");
  AST_LOW_WORD: assert property (v1[4:0] == 5'h00 && v2[4:0] == 5'h00) else $error("lw");
  AST_CH2_FULL: assert property (DUAL_CHANNEL && ch2_conv_done_i &&
    ch2_source_sample_time_sel_i == 2'b11 |=> v2 == {$past(ch2_conv_code_i), 5'h00})
    else $error("full2");
endmodule
bind svr_regs svr_assertions #(.DUAL_CHANNEL(DUAL_CHANNEL)) u_chk (.*);

// ### verif/svr_host.sv
// Purpose: management host model issuing byte reads
// Assumes: one-cycle strobe, data one cycle later
// Notes:   released address shows its inverse
`timescale 1ns/1ps
module svr_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o
);
  initial begin
    reg_rd_o   = 1'b0;
    reg_addr_o = 8'hFF;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) #1;
    reg_rd_o   = 1'b1;
    reg_addr_o = a;
    @(posedge ref_clk_i) #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    d          = reg_rdata_i; // settled data, no edge race
  endtask
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench of the source voltage results
// Assumes: host model reads, bench drives conversions
// Notes:   expectations from an integer model
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_i  = 1'b0;
  logic        reset_i    = 1'b1;
  logic [10:0] cc[2]      = '{11'h000, 11'h000};
  logic        dn[2]      = '{1'b0, 1'b0};
  logic [1:0]  sl[2]      = '{2'b11, 2'b11};
  logic        rd, rv;
  logic [7:0]  ad, rdata, rdata_s;
  logic [15:0] o1, o2, o1s, o2s;
  logic [31:0] seed       = 32'hB3F3;
  int          mismatches = 0, cmp_count = 0, m[2] = '{0, 0}, cap;
  always #10 ref_clk_i = ~ref_clk_i;
  svr_regs dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ch1_conv_code_i(cc[0]),
    .ch1_conv_done_i(dn[0]), .ch1_source_sample_time_sel_i(sl[0]), .ch2_conv_code_i(cc[1]),
    .ch2_conv_done_i(dn[1]), .ch2_source_sample_time_sel_i(sl[1]), .reg_rd_i(rd),
    .reg_addr_i(ad), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .ch1_source_volt_code_o(o1),
    .ch2_source_volt_code_o(o2));
  // single-channel variant sees the same stimulus
  svr_regs #(.DUAL_CHANNEL(1'b0)) dut_single (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .ch1_conv_code_i(cc[0]), .ch1_conv_done_i(dn[0]), .ch1_source_sample_time_sel_i(sl[0]),
    .ch2_conv_code_i(cc[1]), .ch2_conv_done_i(dn[1]), .ch2_source_sample_time_sel_i(sl[1]),
    .reg_rd_i(rd), .reg_addr_i(ad), .reg_rdata_o(rdata_s), .reg_rvalid_o(),
    .ch1_source_volt_code_o(o1s), .ch2_source_volt_code_o(o2s));
  svr_host host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_rd_o(rd), .reg_addr_o(ad));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input int e);
    logic [7:0]  d;
    logic [15:0] es;
    host.rd(a, d);
    chk("byte", {8'h00, e[7:0]}, {8'h00, d});
    chk("rvalid", 16'h0001, {15'h0000, rv});
    es = (a == 8'h13 || a == 8'h14) ? 16'h0000 : {8'h00, e[7:0]};
    chk("single byte", es, {8'h00, rdata_s});
  endtask
  task automatic conv(input int ch, input logic [10:0] c, input logic [1:0] s);
    @(posedge ref_clk_i) #1;
    cc[ch] = c;
    sl[ch] = s;
    dn[ch] = 1'b1;
    @(posedge ref_clk_i) #1;
    dn[ch] = 1'b0;
    cc[ch] = ~c; // code only qualifies the done cycle
    m[ch]  = ((c >> (3 - s)) << (3 - s)) << 5;
    chk("word", m[ch][15:0], ch ? o2 : o1);
    chk("single word", ch ? 16'h0000 : m[ch][15:0], ch ? o2s : o1s);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    for (int a = 8'h10; a <= 8'h15; a++) rdc(8'(a), 0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      conv(i % 2, seed[10:0], 2'(i / 2));
      cap = m[i % 2];
      rdc(8'(8'h11 + 2 * (i % 2)), cap >> 8);
      conv(i % 2, seed[21:11], 2'b11);
      rdc(8'(8'h12 + 2 * (i % 2)), cap);
    end
    conv(0, 11'h400, 2'b11);
    conv(1, 11'h7FF, 2'b00);
    rdc(8'h12, m[0]);
    rdc(8'h14, m[1]);
    $display("test codes done");
    @(posedge ref_clk_i) #1 reset_i = 1'b1;
    @(posedge ref_clk_i) #1 reset_i = 1'b0;
    rdc(8'h11, 0);
    rdc(8'h13, 0);
    $display("test second reset done");
    conclude();
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
